// ### logic/dpm_pkg.sv
// constants, register map and carrier types for the pin mux block
// assumes one clock domain and a 32-bit avalon-mm register port
package dpm_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_SYSCTL   = 5'h00;
  localparam logic [4:0] OFS_FLAG_DIR = 5'h04;
  localparam logic [4:0] OFS_FLAG_OUT = 5'h08;
  localparam logic [4:0] OFS_FLAG_IN  = 5'h0c;
  localparam logic [4:0] OFS_STRAP    = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
  localparam logic [4:0] OFS_BUS      = 5'h1c;

  // interrupt status bit positions
  localparam int unsigned NIRQ          = 6;
  localparam int unsigned IRQ_EDGE_ONLY = 0;
  localparam int unsigned IRQ_LEVEL_A   = 1;
  localparam int unsigned IRQ_LEVEL_B   = 2;
  localparam int unsigned IRQ_CFG_2     = 3;
  localparam int unsigned IRQ_SER_0     = 4;
  localparam int unsigned IRQ_SER_1     = 5;

  // flag pin positions of the shared interrupt pins
  localparam int unsigned PF_EDGE_ONLY = 4;
  localparam int unsigned PF_LEVEL_A   = 5;
  localparam int unsigned PF_LEVEL_B   = 6;
  localparam int unsigned PF_CFG_2     = 7;

  // data pin positions used by the host port in host mode
  localparam int unsigned D_HWR  = 7;
  localparam int unsigned D_HRD  = 6;
  localparam int unsigned D_HAL  = 5;
  localparam int unsigned D_HSEL = 4;
  localparam int unsigned D_HACK = 3;

  // cycles the strap window stays open after reset release
  localparam logic [2:0] STRAP_HOLD = 3'h6;

  // sampled mode straps, mode d down to mode a
  typedef struct packed {
    logic ack_pp;
    logic host_mode;
    logic mode_b;
    logic mode_a;
  } dpm_strap_s;

  // system control register, bit 0 is serial
  typedef struct packed {
    logic irq1_edge;
    logic irq0_edge;
    logic irq_configurable_2_edge;
    logic serial;
  } dpm_sysctl_s;

  // host port strobes handed to the core
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic al;
    logic sel_n;
  } dpm_hctl_s;

  localparam dpm_sysctl_s SYSCTL_RST = 4'h1;
  localparam dpm_hctl_s   HCTL_IDLE  = 4'hd;

endpackage : dpm_pkg

// ### logic/dpm_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin inputs and an active high async reset
module dpm_sync3 #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         MCLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  import dpm_pkg::*;

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // shift chain, first stage read only by the second
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= D;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit changes only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_filt
    always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
        Q[i] <= INIT[i];
      end else if (s2_ff[i] == s3_ff[i]) begin
        Q[i] <= s3_ff[i];
      end
    end
  end

endmodule : dpm_sync3

// ### logic/dpm_pin_mux.sv
// pin function mux, mode straps, shared irq/flag pins, bus grant
// assumes a core behind the CORE_/HOST_/SER_ ports on the same clock
module dpm_pin_mux (
  input  wire logic                 MCLK,
  input  wire logic                 RST,
  input  wire logic [4:0]           AVS_ADDRESS,
  input  wire logic                 AVS_READ,
  input  wire logic                 AVS_WRITE,
  input  wire logic [31:0]          AVS_WRITEDATA,
  input  wire logic [3:0]           AVS_BYTEENABLE,
  output logic      [31:0]          AVS_READDATA,
  output logic                      AVS_WAITREQUEST,
  output logic                      IRQ,
  input  wire logic [7:0]           PF_I,
  output logic      [7:0]           PF_O,
  output logic      [7:0]           PF_OE,
  input  wire logic                 EXT_BUS_REQ_N,
  output logic                      EXT_BUS_GRANT_N,
  output logic                      BUS_GRANT_HUNG_N,
  input  wire logic [13:0]          ADDR_I,
  output logic      [13:0]          ADDR_O,
  output logic      [13:0]          ADDR_OE,
  input  wire logic [23:0]          DATA_I,
  output logic      [23:0]          DATA_O,
  output logic      [23:0]          DATA_OE,
  input  wire logic [1:0]           SP_FS_I,
  output logic      [1:0]           SP_FS_O,
  output logic      [1:0]           SP_FS_OE,
  input  wire logic                 SP_DR,
  output logic                      SP_DT,
  input  wire logic [13:0]          CORE_ADDR,
  input  wire logic [23:0]          CORE_WDATA,
  input  wire logic                 CORE_DRIVE,
  input  wire logic                 CORE_BYTE,
  input  wire logic [7:0]           CORE_BADDR,
  input  wire logic                 CORE_EXT_REQ,
  input  wire logic                 CORE_BUS_FREE,
  output logic      [23:0]          CORE_RDATA,
  input  wire logic [15:0]          HOST_IAD_O,
  input  wire logic                 HOST_IAD_OE,
  input  wire logic                 HOST_ACK_N,
  output logic      [15:0]          HOST_IAD_I,
  output dpm_pkg::dpm_hctl_s        HOST_CTL,
  output dpm_pkg::dpm_strap_s       MODE,
  input  wire logic [1:0]           SER_FS_O,
  input  wire logic [1:0]           SER_FS_OE,
  input  wire logic                 SER_DT,
  output logic      [1:0]           SER_FS_I,
  output logic                      SER_DR
);
  import dpm_pkg::*;

  logic [7:0]      pf_s;
  logic            req_n_s;
  logic [1:0]      fs_s;
  logic            dr_s;
  logic [13:0]     addr_s;
  logic [23:0]     data_s;
  logic            hold_ff;
  logic [2:0]      hold_cnt_ff;
  dpm_strap_s      strap_ff;
  logic [3:0]      strap_s1_ff;
  logic [3:0]      strap_s2_ff;
  logic [3:0]      strap_s3_ff;
  dpm_sysctl_s     sys_ff;
  logic [7:0]      dir_ff;
  logic [8:0]      fout_ff;
  logic [NIRQ-1:0] stat_ff;
  logic [NIRQ-1:0] mask_ff;
  logic [NIRQ-1:0] act_prev_ff;
  logic            granted_ff;
  logic            wait_ff;
  logic            bus_own;
  logic [7:0]      pf_eff;
  logic [NIRQ-1:0] act;
  logic [NIRQ-1:0] edge_sel;
  logic [NIRQ-1:0] fire;
  logic [NIRQ-1:0] clr;
  logic            do_wr;
  logic [31:0]     nxt_rdata;
  logic [13:0]     nxt_addr_o;
  logic [13:0]     nxt_addr_oe;
  logic [23:0]     nxt_data_o;
  logic [23:0]     nxt_data_oe;
  logic [15:0]     nxt_iad_i;
  dpm_hctl_s       nxt_hctl;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  dpm_sync3 #(
    .W    (50),
    .INIT ('1)
  ) u_sync (
    .MCLK (MCLK),
    .RST  (RST),
    .D    ({DATA_I, ADDR_I, SP_DR, SP_FS_I, EXT_BUS_REQ_N, PF_I}),
    .Q    ({data_s, addr_s, dr_s, fs_s, req_n_s, pf_s})
  );

  //////////////////////////////////////////////////////////////////////
  // settle window: flag, address and data pins stay released a few cycles after reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hold_cnt_ff <= STRAP_HOLD;
      hold_ff     <= 1'b1;
    end else begin
      if (hold_cnt_ff != 3'h0) begin
        hold_cnt_ff <= hold_cnt_ff - 3'h1;
      end
      hold_ff <= (hold_cnt_ff != 3'h0);
    end
  end

  // strap chain has no reset, so the mode pins are seen during reset
  always_ff @(posedge MCLK) begin
    strap_s1_ff <= PF_I[3:0];
    strap_s2_ff <= strap_s1_ff;
    strap_s3_ff <= strap_s2_ff;
  end

  // strap capture only while reset is held, frozen after release
  always_ff @(posedge MCLK) begin
    if (RST && strap_s2_ff == strap_s3_ff) begin
      strap_ff <= strap_s3_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer
  assign do_wr = AVS_WRITE & ~wait_ff;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((AVS_READ | AVS_WRITE) & wait_ff);
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      OFS_SYSCTL:   nxt_rdata[3:0] = sys_ff;
      OFS_FLAG_DIR: nxt_rdata[7:0] = dir_ff;
      OFS_FLAG_OUT: nxt_rdata[8:0] = fout_ff;
      OFS_FLAG_IN:  nxt_rdata[8:0] = {dr_s, pf_s};
      OFS_STRAP:    nxt_rdata[3:0] = strap_ff;
      OFS_IRQ_STAT: nxt_rdata[NIRQ-1:0] = stat_ff;
      OFS_IRQ_MASK: nxt_rdata[NIRQ-1:0] = mask_ff;
      OFS_BUS:      nxt_rdata[1:0] = {~BUS_GRANT_HUNG_N, granted_ff};
      default:      nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ & wait_ff) begin
      AVS_READDATA <= nxt_rdata;
    end
  end

  assign AVS_WAITREQUEST = wait_ff;

  // writable control registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sys_ff  <= SYSCTL_RST;
      dir_ff  <= '0;
      fout_ff <= '1;
      mask_ff <= '0;
    end else begin
      if (do_wr & AVS_BYTEENABLE[0]) begin
        unique case (AVS_ADDRESS)
          OFS_SYSCTL:   sys_ff <= AVS_WRITEDATA[3:0];
          OFS_FLAG_DIR: dir_ff <= AVS_WRITEDATA[7:0];
          OFS_FLAG_OUT: fout_ff[7:0] <= AVS_WRITEDATA[7:0];
          OFS_IRQ_MASK: mask_ff <= AVS_WRITEDATA[NIRQ-1:0];
          default:      ;
        endcase
      end
      if (do_wr && AVS_BYTEENABLE[1] && AVS_ADDRESS == OFS_FLAG_OUT) begin
        fout_ff[8] <= AVS_WRITEDATA[8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt sources: pin level includes our own flag drive
  assign pf_eff = (PF_O & PF_OE) | (pf_s & ~PF_OE);

  always_comb begin
    act = '0;
    act[IRQ_EDGE_ONLY] = ~pf_eff[PF_EDGE_ONLY];
    act[IRQ_LEVEL_A]   = ~pf_eff[PF_LEVEL_A];
    act[IRQ_LEVEL_B]   = ~pf_eff[PF_LEVEL_B];
    act[IRQ_CFG_2]     = ~pf_eff[PF_CFG_2];
    act[IRQ_SER_0]     = ~fs_s[0] & ~sys_ff.serial;
    act[IRQ_SER_1]     = ~fs_s[1] & ~sys_ff.serial;
    edge_sel = '0;
    edge_sel[IRQ_EDGE_ONLY] = 1'b1;
    edge_sel[IRQ_CFG_2]     = sys_ff.irq_configurable_2_edge;
    edge_sel[IRQ_SER_0]     = sys_ff.irq0_edge;
    edge_sel[IRQ_SER_1]     = sys_ff.irq1_edge;
  end

  // edge inputs fire at assertion, level inputs while held
  assign fire = hold_ff ? '0
              : (edge_sel & act & ~act_prev_ff) | (~edge_sel & act);
  assign clr  = (do_wr && AVS_ADDRESS == OFS_IRQ_STAT && AVS_BYTEENABLE[0])
              ? AVS_WRITEDATA[NIRQ-1:0] : '0;

  // sticky status, a set beats a same-cycle clear
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      stat_ff     <= '0;
      act_prev_ff <= '0;
      IRQ         <= 1'b0;
    end else begin
      stat_ff     <= (stat_ff & ~clr) | fire;
      act_prev_ff <= act;
      IRQ         <= |(stat_ff & mask_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // programmable flags, inputs only while the strap window is open
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PF_O  <= '1;
      PF_OE <= '0;
    end else begin
      PF_O  <= fout_ff[7:0];
      PF_OE <= hold_ff ? 8'h00 : dir_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // external bus request, grant and grant-hung
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      granted_ff       <= 1'b0;
      EXT_BUS_GRANT_N  <= 1'b1;
      BUS_GRANT_HUNG_N <= 1'b1;
    end else begin
      if (req_n_s) begin
        granted_ff      <= 1'b0;
        EXT_BUS_GRANT_N <= 1'b1;
      end else if (CORE_BUS_FREE & ~hold_ff) begin
        granted_ff      <= 1'b1;
        EXT_BUS_GRANT_N <= 1'b0;
      end
      BUS_GRANT_HUNG_N <= ~(granted_ff & CORE_EXT_REQ);
    end
  end

  assign bus_own = ~granted_ff & ~hold_ff;

  //////////////////////////////////////////////////////////////////////
  // shared bus pins, role chosen by the captured memory-mode strap
  always_comb begin
    nxt_addr_o  = CORE_ADDR;
    nxt_addr_oe = {14{bus_own}};
    nxt_data_o  = CORE_BYTE ? {CORE_BADDR, CORE_WDATA[15:0]} : CORE_WDATA;
    nxt_data_oe = {24{bus_own & CORE_DRIVE}};
    if (bus_own & CORE_BYTE) begin
      nxt_data_oe[23:16] = 8'hff;
    end
    nxt_hctl  = HCTL_IDLE;
    nxt_iad_i = 16'h0000;
    if (strap_ff.host_mode) begin
      nxt_addr_o[13:1]  = HOST_IAD_O[12:0];
      nxt_addr_oe[13:1] = {13{HOST_IAD_OE}};
      nxt_data_o[2:0]   = HOST_IAD_O[15:13];
      nxt_data_oe[2:0]  = {3{HOST_IAD_OE}};
      nxt_data_oe[D_HWR:D_HSEL] = 4'h0;
      nxt_data_o[D_HWR:D_HSEL]  = 4'h0;
      nxt_data_o[D_HACK]  = strap_ff.ack_pp & HOST_ACK_N;
      nxt_data_oe[D_HACK] = strap_ff.ack_pp | ~HOST_ACK_N;
      nxt_hctl.wr_n  = data_s[D_HWR];
      nxt_hctl.rd_n  = data_s[D_HRD];
      nxt_hctl.al    = data_s[D_HAL];
      nxt_hctl.sel_n = data_s[D_HSEL];
      nxt_iad_i      = {data_s[2:0], addr_s[13:1]};
    end
    if (hold_ff) begin
      nxt_addr_oe = '0;
      nxt_data_oe = '0;
    end
  end

  // registered pin drive and core-side returns
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ADDR_O     <= '0;
      ADDR_OE    <= '0;
      DATA_O     <= '0;
      DATA_OE    <= '0;
      HOST_CTL   <= HCTL_IDLE;
      HOST_IAD_I <= '0;
      CORE_RDATA <= '0;
      MODE       <= '0;
    end else begin
      ADDR_O     <= nxt_addr_o;
      ADDR_OE    <= nxt_addr_oe;
      DATA_O     <= nxt_data_o;
      DATA_OE    <= nxt_data_oe;
      HOST_CTL   <= nxt_hctl;
      HOST_IAD_I <= nxt_iad_i;
      CORE_RDATA <= strap_ff.host_mode ? {data_s[23:8], 8'h00} : data_s;
      MODE       <= strap_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // second serial port pins: serial signals or irq/flag pair
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SP_FS_O  <= '0;
      SP_FS_OE <= '0;
      SP_DT    <= 1'b1;
      SER_FS_I <= '1;
      SER_DR   <= 1'b0;
    end else if (sys_ff.serial) begin
      SP_FS_O  <= SER_FS_O;
      SP_FS_OE <= SER_FS_OE;
      SP_DT    <= SER_DT;
      SER_FS_I <= fs_s;
      SER_DR   <= dr_s;
    end else begin
      SP_FS_O  <= '0;
      SP_FS_OE <= 2'b00;
      SP_DT    <= fout_ff[8];
      SER_FS_I <= '1;
      SER_DR   <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_bus_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence

  sequence s_bus_ans;
    ##1 !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  property p_bus_answer;
    s_bus_req |-> s_bus_ans;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not after one wait cycle");

  property p_strap_fixed;
    !hold_ff |=> $stable(strap_ff) && MODE == $past(strap_ff);
  endproperty
  a_strap_fixed: assert property (p_strap_fixed)
    else $error("mode strap changed outside the strap window");

  property p_mode_pins_in;
    hold_ff |=> PF_OE == 8'h00 && ADDR_OE == 14'h0000;
  endproperty
  a_mode_pins_in: assert property (p_mode_pins_in)
    else $error("pins driven while straps are sampled");

  property p_flag_dir;
    !hold_ff |=> PF_OE == $past(dir_ff) && PF_O == $past(fout_ff[7:0]);
  endproperty
  a_flag_dir: assert property (p_flag_dir)
    else $error("flag pins do not follow direction and value");

  property p_irq_out;
    (stat_ff & mask_ff) != '0 |=> IRQ;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("unmasked status did not raise the interrupt");

  property p_edge_only;
    !hold_ff && act[IRQ_EDGE_ONLY] && !act_prev_ff[IRQ_EDGE_ONLY]
      |=> stat_ff[IRQ_EDGE_ONLY];
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("edge interrupt not latched");

  property p_level_b;
    !hold_ff && !pf_eff[PF_LEVEL_B] |=> stat_ff[IRQ_LEVEL_B] ##1 1'b1;
  endproperty
  a_level_b: assert property (p_level_b)
    else $error("level interrupt not latched");

  property p_serial_off;
    !sys_ff.serial |=> SP_FS_OE == 2'b00 && SP_DT == $past(fout_ff[8]);
  endproperty
  a_serial_off: assert property (p_serial_off)
    else $error("serial pins driven in flag mode");

  property p_full_idle;
    !strap_ff.host_mode |=> HOST_CTL == HCTL_IDLE && HOST_IAD_I == '0;
  endproperty
  a_full_idle: assert property (p_full_idle)
    else $error("host port active in full memory mode");

  property p_byte_addr;
    !strap_ff.host_mode && bus_own && CORE_BYTE
      |=> DATA_OE[23:16] == 8'hff && DATA_O[23:16] == $past(CORE_BADDR);
  endproperty
  a_byte_addr: assert property (p_byte_addr)
    else $error("byte address missing from upper data pins");

  property p_grant;
    !req_n_s && CORE_BUS_FREE && !hold_ff |=> !EXT_BUS_GRANT_N;
  endproperty
  a_grant: assert property (p_grant)
    else $error("bus request not granted");

endmodule : dpm_pin_mux

// ### sim/dpm_pin_partner.sv
// far side of the pin mux: flag pins with pull-ups, host or memory on the
// shared bus pins, and an outside bus requester
// assumes pin outputs of the mux and plain commands from the bench
module dpm_pin_partner (
  input  wire logic        clk,
  input  wire logic [7:0]  pf_o,
  input  wire logic [7:0]  pf_oe,
  input  wire logic [7:0]  pf_ext,
  input  wire logic [13:0] addr_o,
  input  wire logic [13:0] addr_oe,
  input  wire logic [13:0] host_addr,
  input  wire logic [23:0] data_o,
  input  wire logic [23:0] data_oe,
  input  wire logic [23:0] host_data,
  input  wire logic        bus_want,
  output logic      [7:0]  pf_i,
  output logic      [13:0] addr_i,
  output logic      [23:0] data_i,
  output logic             bus_req_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////
  // wire level: device drive wins, else outside driver or pull-up
  assign pf_i   = (pf_oe & pf_o) | (~pf_oe & pf_ext);
  assign addr_i = (addr_oe & addr_o) | (~addr_oe & host_addr);
  assign data_i = (data_oe & data_o) | (~data_oe & host_data);
  //////////////////////////////////////////////////////////////////////////
  // requester changes its request just after a clock edge
  always @(posedge clk) begin
    bus_req_n <= ~bus_want;
  end
endmodule : dpm_pin_partner

// ### sim/tb_dsp_pin_mode_strap_mux.sv
// testbench of the pin mux: straps, flags, shared irqs, serial, bus pins
// assumes dpm_pin_mux, dpm_pkg and the partner model in sim/
module tb_dsp_pin_mode_strap_mux import dpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic        avs_waitrequest, irq, bus_req_n, grant_n, hung_n, bus_want;
  logic [7:0]  pf_i, pf_o, pf_oe, pf_ext, core_baddr;
  logic [13:0] addr_i, addr_o, addr_oe, host_addr, core_addr;
  logic [23:0] data_i, data_o, data_oe, host_data, core_wdata, core_rdata;
  logic [1:0]  sp_fs_i = 2'b11, sp_fs_o, sp_fs_oe, ser_fs_i;
  logic        sp_dt, ser_dr, core_drive, core_byte, core_ext_req;
  logic        core_bus_free = 1'b1, host_ack_n = 1'b1, host_iad_oe = 1'b0;
  logic [15:0] host_iad_i, host_iad_o = 16'h0000;
  dpm_hctl_s   host_ctl;
  dpm_strap_s  mode;
  int          err_count = 0, compares = 0, cycles = 0;
  localparam logic [4:0]  ROW_A [5] = '{OFS_SYSCTL, OFS_FLAG_DIR,
    OFS_FLAG_OUT, OFS_BUS, 5'h02};
  localparam logic [31:0] ROW_E [5] = '{32'h0000_0001, 32'h0000_0000,
    32'h0000_01ff, 32'h0000_0000, 32'h0000_0000};

  //////////////////////////////////////////////////////////////////////////
  // clock and design under test
  always #4 mclk = ~mclk;
  dpm_pin_mux dut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .IRQ(irq), .PF_I(pf_i), .PF_O(pf_o), .PF_OE(pf_oe),
    .EXT_BUS_REQ_N(bus_req_n), .EXT_BUS_GRANT_N(grant_n),
    .BUS_GRANT_HUNG_N(hung_n), .ADDR_I(addr_i), .ADDR_O(addr_o),
    .ADDR_OE(addr_oe), .DATA_I(data_i), .DATA_O(data_o),
    .DATA_OE(data_oe), .SP_FS_I(sp_fs_i), .SP_FS_O(sp_fs_o),
    .SP_FS_OE(sp_fs_oe), .SP_DR(1'b0), .SP_DT(sp_dt),
    .CORE_ADDR(core_addr), .CORE_WDATA(core_wdata),
    .CORE_DRIVE(core_drive), .CORE_BYTE(core_byte),
    .CORE_BADDR(core_baddr), .CORE_EXT_REQ(core_ext_req),
    .CORE_BUS_FREE(core_bus_free), .CORE_RDATA(core_rdata),
    .HOST_IAD_O(host_iad_o), .HOST_IAD_OE(host_iad_oe),
    .HOST_ACK_N(host_ack_n), .HOST_IAD_I(host_iad_i),
    .HOST_CTL(host_ctl), .MODE(mode), .SER_FS_O(2'b00),
    .SER_FS_OE(2'b00), .SER_DT(1'b1), .SER_FS_I(ser_fs_i),
    .SER_DR(ser_dr));
  dpm_pin_partner far (.clk(mclk), .pf_o(pf_o), .pf_oe(pf_oe),
    .pf_ext(pf_ext), .addr_o(addr_o), .addr_oe(addr_oe),
    .host_addr(host_addr), .data_o(data_o), .data_oe(data_oe),
    .host_data(host_data), .bus_want(bus_want), .pf_i(pf_i),
    .addr_i(addr_i), .data_i(data_i), .bus_req_n(bus_req_n));

  //////////////////////////////////////////////////////////////////////////
  // verdict, compare and bus helpers
  task end_sim;
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~w;
    avs_write     <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd_chk
  // reset with a strap pattern, held past the strap window, then moved
  task do_reset(input logic [3:0] s);
    @(posedge mclk);
    rst    <= 1'b1;
    pf_ext <= {4'hf, s};
    cyc(10);
    chk({avs_waitrequest, irq, grant_n, hung_n, pf_o}, 12'hbff);
    chk(|{pf_oe, addr_oe, data_oe, sp_fs_oe}, 1'b0);
    rst <= 1'b0;
    cyc(12);
    chk(mode, s);
    pf_ext[3:0] <= ~s;
    cyc(8);
    chk(mode, s);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pf_ext = 8'hff; host_addr = '0; host_data = '0; bus_want = 1'b0;
    core_addr = '0; core_wdata = '0; core_baddr = '0; core_drive = 1'b0;
    core_byte = 1'b0; core_ext_req = 1'b0;
    do_reset(4'ha);
    // register reset values and an unmapped offset
    for (int i = 0; i < 5; i++) rd_chk(ROW_A[i], ROW_E[i]);
    // mode pins and pf7 as outputs, pf7 low raises its shared irq
    wr(OFS_FLAG_DIR, 32'h0000_008f);
    wr(OFS_FLAG_OUT, 32'h0000_0175);
    cyc(8);
    chk({pf_oe, pf_o[3:0]}, 12'h8f5);
    rd_chk(OFS_FLAG_IN, 32'h0000_0075);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0008);
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0008);
    cyc(3);
    chk(irq, 1'b1);
    // edge-only, level and configurable-as-edge pins held low
    wr(OFS_SYSCTL, 32'h0000_0003);
    pf_ext[6:4] <= 3'b000;
    cyc(8);
    wr(OFS_IRQ_STAT, 32'h0000_003f);
    cyc(4);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0006);
    pf_ext[6:4] <= 3'b111;
    wr(OFS_SYSCTL, 32'h0000_0001);
    wr(OFS_FLAG_OUT, 32'h0000_01ff);
    cyc(8);
    wr(OFS_IRQ_STAT, 32'h0000_003f);
    cyc(3);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0000);
    chk(irq, 1'b0);
    // serial pins switched at run time
    sp_fs_i <= 2'b01;
    cyc(8);
    chk(ser_fs_i, 2'b01);
    wr(OFS_SYSCTL, 32'h0000_0000);
    wr(OFS_FLAG_OUT, 32'h0000_00ff);
    sp_fs_i <= 2'b00;
    cyc(8);
    chk({ser_fs_i, ser_dr, sp_dt, sp_fs_oe}, 6'h30);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0030);
    sp_fs_i <= 2'b10;
    wr(OFS_SYSCTL, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_003f);
    cyc(8);
    chk({ser_fs_i, sp_dt}, 3'h5);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0000);
    // outside bus request, grant and hung status
    bus_want <= 1'b1;
    for (int i = 0; i < 20 && grant_n !== 1'b0; i++) @(posedge mclk);
    chk(grant_n, 1'b0);
    core_ext_req <= 1'b1;
    cyc(3);
    chk(hung_n, 1'b0);
    rd_chk(OFS_BUS, 32'h0000_0003);
    bus_want     <= 1'b0;
    core_ext_req <= 1'b0;
    cyc(8);
    chk({grant_n, hung_n}, 2'b11);
    // full memory mode byte access on the shared pins
    core_addr  <= 14'h2a5c;
    core_wdata <= 24'h00_5a3c;
    core_baddr <= 8'hc3;
    core_byte  <= 1'b1;
    core_drive <= 1'b1;
    cyc(3);
    chk({addr_oe, addr_o}, {14'h3fff, 14'h2a5c});
    chk({data_oe, data_o[23:16]}, 32'hffff_ffc3);
    chk({host_iad_i, host_ctl}, {16'h0000, HCTL_IDLE});
    // host mode after a second reset
    core_drive <= 1'b0;
    do_reset(4'h4);
    host_addr <= 14'h1556;
    host_data <= 24'h00_009d;
    cyc(8);
    chk(host_iad_i, 16'haaab);
    chk(host_ctl, 4'h9);
    chk(core_rdata, 24'hc3_0000);
    chk(addr_oe[13:1], 13'h0000);
    host_ack_n <= 1'b0;
    cyc(3);
    chk({data_oe[3], data_o[3]}, 2'b10);
    host_ack_n <= 1'b1;
    cyc(3);
    chk(data_oe[3], 1'b0);
    end_sim();
  end
endmodule : tb_dsp_pin_mode_strap_mux
